//--- logic/ldr_dimming_regs.sv
// Purpose: dimming register bank for channels 15 and 16 on ahb-lite
// Assumes: single word transfers; one slave so hreadyout is the bus hready
// Notes:   writes take no wait state, reads take one
//
// Design decision made here: the AHB-Lite slave port.

`timescale 1ns/1ps
`default_nettype none

module ldr_dimming_regs (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [ldr_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic      [31:0]                 hrdata,
  output logic                             hresp,
  // applied dimming settings
  output ldr_pkg::ldr_dimming_t            dimming
);

  // true when a byte address hits the register of the given index
  function automatic logic hits(input logic [ldr_pkg::ADDR_W-1:0] a,
                                input logic [7:0] idx);
    hits = (a == {idx, 2'b00});
  endfunction

  ldr_pkg::ldr_bus_state_t  state;
  ldr_pkg::ldr_bus_state_t  next_state;
  ldr_pkg::ldr_addr_phase_t aph;
  ldr_pkg::ldr_addr_phase_t next_aph;
  logic [31:0]              next_hrdata;
  logic [5:0]               analog;
  logic [5:0]               next_analog;

  logic        take;
  logic        wr_now;
  logic        we15_lo;
  logic        we15_hi;
  logic        we16_lo;
  logic        we16_hi;
  logic [3:0]  lo15;
  logic [7:0]  hi15;
  logic [3:0]  lo16;
  logic [7:0]  hi16;
  logic [11:0] duty15;
  logic [11:0] duty16;

  // size is not checked: only whole-word singles are expected
  assign take      = hsel && hready && (htrans == ldr_pkg::HTRANS_NSEQ ||
                                        htrans == 2'h3);
  // reads stall one cycle so hrdata comes from a register
  assign hreadyout = (state != ldr_pkg::LDR_ST_RD);
  assign hresp     = ldr_pkg::HRESP_OKAY;

  always_comb begin
    next_state  = state;
    next_aph    = aph;
    next_hrdata = hrdata;
    case (state)
      ldr_pkg::LDR_ST_IDLE,
      ldr_pkg::LDR_ST_WR,
      ldr_pkg::LDR_ST_RDONE: begin
        if (take) begin
          next_aph.addr  = haddr;
          next_aph.write = hwrite;
          next_state     = hwrite ? ldr_pkg::LDR_ST_WR : ldr_pkg::LDR_ST_RD;
        end else begin
          next_state = ldr_pkg::LDR_ST_IDLE;
        end
      end
      ldr_pkg::LDR_ST_RD: begin
        // unmapped and reserved bits read as zero
        next_hrdata = 32'h0;
        if (hits(aph.addr, ldr_pkg::CH15_DUTY_LOW_IDX)) begin
          next_hrdata = {28'h0, lo15};
        end else if (hits(aph.addr, ldr_pkg::CH15_DUTY_HIGH_IDX)) begin
          next_hrdata = {24'h0, hi15};
        end else if (hits(aph.addr, ldr_pkg::CH16_ANALOG_LEVEL_IDX)) begin
          next_hrdata = {26'h0, analog};
        end else if (hits(aph.addr, ldr_pkg::CH16_DUTY_LOW_IDX)) begin
          next_hrdata = {28'h0, lo16};
        end else if (hits(aph.addr, ldr_pkg::CH16_DUTY_HIGH_IDX)) begin
          next_hrdata = {24'h0, hi16};
        end
        next_state = ldr_pkg::LDR_ST_RDONE;
      end
      default: begin
        next_state = ldr_pkg::LDR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= ldr_pkg::LDR_ST_IDLE;
      aph    <= '0;
      hrdata <= 32'h0;
    end else begin
      state  <= next_state;
      aph    <= next_aph;
      hrdata <= next_hrdata;
    end
  end

  // write strobes land in the data phase, when hwdata is valid
  assign wr_now  = (state == ldr_pkg::LDR_ST_WR);
  assign we15_lo = wr_now && hits(aph.addr, ldr_pkg::CH15_DUTY_LOW_IDX);
  assign we15_hi = wr_now && hits(aph.addr, ldr_pkg::CH15_DUTY_HIGH_IDX);
  assign we16_lo = wr_now && hits(aph.addr, ldr_pkg::CH16_DUTY_LOW_IDX);
  assign we16_hi = wr_now && hits(aph.addr, ldr_pkg::CH16_DUTY_HIGH_IDX);

  always_comb begin
    next_analog = analog;
    if (wr_now && hits(aph.addr, ldr_pkg::CH16_ANALOG_LEVEL_IDX)) begin
      next_analog = hwdata[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog <= ldr_pkg::ANALOG_RST;
    end else begin
      analog <= next_analog;
    end
  end

  ldr_duty_chan #(
    .LOW_W  (ldr_pkg::DUTY_LOW_W),
    .HIGH_W (ldr_pkg::DUTY_HIGH_W)
  ) u_ch15 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .low_we  (we15_lo),
    .high_we (we15_hi),
    .wdata   (hwdata[7:0]),
    .low_q   (lo15),
    .high_q  (hi15),
    .duty    (duty15)
  );

  ldr_duty_chan #(
    .LOW_W  (ldr_pkg::DUTY_LOW_W),
    .HIGH_W (ldr_pkg::DUTY_HIGH_W)
  ) u_ch16 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .low_we  (we16_lo),
    .high_we (we16_hi),
    .wdata   (hwdata[7:0]),
    .low_q   (lo16),
    .high_q  (hi16),
    .duty    (duty16)
  );

  // current sources see only applied values, never the staged nibble
  assign dimming.chan15_duty        = duty15;
  assign dimming.chan16_duty        = duty16;
  assign dimming.chan16_analog_code = analog;

endmodule

`default_nettype wire

//--- logic/ldr_duty_chan.sv
// Purpose: one channel's staged 12-bit duty value
// Assumes: write strobes are one-cycle pulses on hclk
// Notes:   low nibble only stages; high byte write applies all bits at once

`timescale 1ns/1ps
`default_nettype none

module ldr_duty_chan #(
  parameter int LOW_W  = 4,
  parameter int HIGH_W = 8
) (
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // write side
  input  wire logic                    low_we,
  input  wire logic                    high_we,
  input  wire logic [7:0]              wdata,
  // state
  output logic      [LOW_W-1:0]        low_q,
  output logic      [HIGH_W-1:0]       high_q,
  output logic      [LOW_W+HIGH_W-1:0] duty
);

  generate
    if (LOW_W != ldr_pkg::DUTY_LOW_W || HIGH_W != ldr_pkg::DUTY_HIGH_W) begin : g_chk
      $error("ldr_duty_chan: field widths must be 4 and 8");
    end
  endgenerate

  logic [LOW_W-1:0]        next_low_q;
  logic [HIGH_W-1:0]       next_high_q;
  logic [LOW_W+HIGH_W-1:0] next_duty;

  always_comb begin
    next_low_q  = low_q;
    next_high_q = high_q;
    next_duty   = duty;
    if (low_we) begin
      // upper bits of the written byte are dropped
      next_low_q = wdata[LOW_W-1:0];
    end
    if (high_we) begin
      next_high_q = wdata[HIGH_W-1:0];
      // staged nibble and new byte go live together
      next_duty   = {wdata[HIGH_W-1:0], next_low_q};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q  <= ldr_pkg::DUTY_LOW_RST;
      high_q <= ldr_pkg::DUTY_HIGH_RST;
      duty   <= ldr_pkg::DUTY_RST;
    end else begin
      low_q  <= next_low_q;
      high_q <= next_high_q;
      duty   <= next_duty;
    end
  end

endmodule

`default_nettype wire

//--- logic/ldr_pkg.sv
// Purpose: shared constants and types for the channel 15/16 dimming bank
// Assumes: registers reached over ahb-lite, one aligned word per register
// Notes:   byte address of a register is four times its index

package ldr_pkg;

  // register indices; byte address = index * 4
  localparam logic [7:0] CH15_DUTY_LOW_IDX     = 8'h35;
  localparam logic [7:0] CH15_DUTY_HIGH_IDX    = 8'h36;
  localparam logic [7:0] CH16_ANALOG_LEVEL_IDX = 8'h37;
  localparam logic [7:0] CH16_DUTY_LOW_IDX     = 8'h38;
  localparam logic [7:0] CH16_DUTY_HIGH_IDX    = 8'h39;

  // field layout
  localparam int DUTY_LOW_W  = 4;
  localparam int DUTY_HIGH_W = 8;
  localparam int DUTY_W      = 12;
  localparam int ANALOG_W    = 6;

  // values after reset
  localparam logic [3:0]  DUTY_LOW_RST    = 4'hf;
  localparam logic [7:0]  DUTY_HIGH_RST   = 8'hff;
  localparam logic [11:0] DUTY_RST        = 12'hfff;
  localparam logic [5:0]  ANALOG_RST      = 6'h3f;
  // analog current = code / ANALOG_FULL_CODE of full_scale_current
  localparam logic [5:0]  ANALOG_FULL_CODE = 6'h3f;

  // bus
  localparam int          ADDR_W      = 10;
  localparam logic [1:0]  HTRANS_IDLE = 2'h0;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic        HRESP_OKAY  = 1'h0;

  typedef enum logic [1:0] {
    LDR_ST_IDLE  = 2'b00,
    LDR_ST_WR    = 2'b01,
    LDR_ST_RD    = 2'b10,
    LDR_ST_RDONE = 2'b11
  } ldr_bus_state_t;

  // captured address phase
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
  } ldr_addr_phase_t;

  // applied dimming settings driven to the current sources
  typedef struct packed {
    logic [DUTY_W-1:0]   chan15_duty;
    logic [DUTY_W-1:0]   chan16_duty;
    logic [ANALOG_W-1:0] chan16_analog_code;
  } ldr_dimming_t;

endpackage

//--- testbench/ldr_ahb_host.sv
// Purpose: ahb-lite master standing in for the serial host
// Assumes: hready and hrdata are taken as each rising edge fires
// Notes:   released write data is inverted so stale bytes never match
`timescale 1ns/1ps
`default_nettype none
module ldr_ahb_host (
  // clock and bus answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic             hwrite,
  output logic [9:0]       haddr,
  output logic [1:0]       htrans,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // waits that ran out
  output int               hangs
);
  initial begin
    {hsel, hwrite, haddr, hwdata, hangs} = '0;
    htrans = ldr_pkg::HTRANS_IDLE;
    hsize = 3'h2;
  end
  task automatic wait_ready(output logic [31:0] q);
    int n;
    n = 0;
    // values seen here are those that stood just before the edge
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 32);
    if (hready !== 1'b1) hangs++;
    q = hrdata;
  endtask
  task automatic xfer(input logic [9:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ldr_pkg::HTRANS_NSEQ;
    wait_ready(q);
    hsel <= 1'b0;
    htrans <= ldr_pkg::HTRANS_IDLE;
    hwdata <= w ? d : ~hwdata;
    wait_ready(q);
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

//--- testbench/ldr_dimming_regs_sva.sv
// Purpose: bus and dimming checks for the dimming register bank
// Assumes: one slave, hready tied to hreadyout
// Notes:   a write data phase is tracked in helper flops
`timescale 1ns/1ps
`default_nettype none
module ldr_dimming_regs_sva (
  // clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  // ahb-lite slave side
  input wire logic                       hsel,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic [ldr_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0]                 htrans,
  input wire logic [2:0]                 hsize,
  input wire logic [31:0]                hwdata,
  input wire logic [31:0]                hrdata,
  // applied settings
  input wire ldr_pkg::ldr_dimming_t      dimming
);
  logic                       taken;
  logic                       wr_v;
  logic                       next_wr_v;
  logic [ldr_pkg::ADDR_W-1:0] wr_a;
  logic [ldr_pkg::ADDR_W-1:0] next_wr_a;
  logic                       wr15_hi;
  logic                       wr16_hi;
  logic                       wr16_code;
  assign taken = hsel && hready && htrans[1];
  always_comb begin
    next_wr_v = taken && hwrite;
    next_wr_a = haddr;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_v <= 1'b0;
      wr_a <= '0;
    end else begin
      wr_v <= next_wr_v;
      wr_a <= next_wr_a;
    end
  end
  // data-phase write strobes, one per watched register
  assign wr15_hi   = wr_v && wr_a == {ldr_pkg::CH15_DUTY_HIGH_IDX, 2'b00};
  assign wr16_hi   = wr_v && wr_a == {ldr_pkg::CH16_DUTY_HIGH_IDX, 2'b00};
  assign wr16_code = wr_v && wr_a == {ldr_pkg::CH16_ANALOG_LEVEL_IDX, 2'b00};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_duty15_set: assert property (
    wr15_hi |=>
    dimming.chan15_duty[11:4] == $past(hwdata[7:0])) else $error("duty15 bad");
  chk_duty16_set: assert property (
    wr16_hi |=>
    dimming.chan16_duty[11:4] == $past(hwdata[7:0])) else $error("duty16 bad");
  chk_duty15_hold: assert property ($changed(dimming.chan15_duty) |->
    $past(wr15_hi)) else $error("duty15 moved");
  chk_duty16_hold: assert property ($changed(dimming.chan16_duty) |->
    $past(wr16_hi)) else $error("duty16 moved");
  chk_analog_set: assert property (
    wr16_code |=>
    dimming.chan16_analog_code == $past(hwdata[5:0])) else $error("code bad");
  chk_analog_hold: assert property (
    $changed(dimming.chan16_analog_code) |-> $past(wr16_code))
    else $error("code moved");
  chk_read_wait: assert property (taken && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait wrong");
  chk_write_nowait: assert property (taken && hwrite |=>
    hreadyout) else $error("write stalled");
  chk_read_upper: assert property (hreadyout && $past(!hreadyout) |->
    hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_resp_okay: assert property (
    hresp == ldr_pkg::HRESP_OKAY) else $error("response not okay");
  cover property (wr15_hi);
  cover property (wr16_code);
  cover property (taken && !hwrite ##2 hreadyout);
endmodule
bind ldr_dimming_regs ldr_dimming_regs_sva chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .htrans(htrans),
  .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .dimming(dimming));
`default_nettype wire

//--- testbench/led_dimming_regs_ch15_16_tb.sv
// Purpose: register and dimming tests for the channel 15/16 bank
// Assumes: registers reached by index times four
// Notes:   dimming is sampled at the falling edge after a write lands
`timescale 1ns/1ps
`default_nettype none
module led_dimming_regs_ch15_16_tb;
  logic                  hclk = 1'b0, hresetn = 1'b0;
  logic                  hsel, hwrite, hreadyout, hresp;
  logic [9:0]            haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata;
  ldr_pkg::ldr_dimming_t dimming;
  int                    failures = 0, n_compared = 0, hangs;
  always #20 hclk = ~hclk;
  ldr_dimming_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dimming(dimming));
  ldr_ahb_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .hwrite(hwrite), .haddr(haddr), .htrans(htrans),
    .hsize(hsize), .hwdata(hwdata), .hangs(hangs));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    host.xfer({idx, 2'b00}, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer({idx, 2'b00}, 1'b0, 32'h0, q);
    check(q, exp);
  endtask
  task automatic dim(input logic [29:0] exp);
    @(negedge hclk);
    check({2'b00, dimming}, {2'b00, exp});
  endtask
  task automatic defaults();
    rd(8'h35, 32'hf);
    rd(8'h36, 32'hff);
    rd(8'h37, 32'h3f);
    rd(8'h38, 32'hf);
    rd(8'h39, 32'hff);
    dim({12'hfff, 12'hfff, 6'h3f});
  endtask
  task automatic conclude();
    failures += hangs;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    defaults();
    $display("test reset values done");
    wr(8'h35, 32'hffffffa5);
    rd(8'h35, 32'h5);
    dim({12'hfff, 12'hfff, 6'h3f});
    wr(8'h36, 32'h3c);
    dim({12'h3c5, 12'hfff, 6'h3f});
    wr(8'h36, 32'hffffff12);
    dim({12'h125, 12'hfff, 6'h3f});
    rd(8'h36, 32'h12);
    wr(8'h38, 32'h7);
    wr(8'h39, 32'ha9);
    rd(8'h39, 32'ha9);
    dim({12'h125, 12'ha97, 6'h3f});
    $display("test duty staging done");
    wr(8'h37, 32'hffffffd5);
    rd(8'h37, 32'h15);
    dim({12'h125, 12'ha97, 6'h15});
    wr(8'h00, 32'h55);
    rd(8'h00, 32'h0);
    dim({12'h125, 12'ha97, 6'h15});
    $display("test analog and unmapped done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    defaults();
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
